// *** core/liss_top.sv ***
`timescale 1ns/1ps
// scan shift-register sequencer of a cascaded linear image sensor
// Behaviour
// - a start pulse high at a shift clock falling edge loads a token
// - start high across several edges loads several tokens, scans overlap
// - one pixel is captured per shift clock cycle while a token is in the chain; a stalled pixel is overwritten
// - one line lasts 13 times 128 shift clock cycles
module liss_top #(
  parameter int DIES   = liss_pkg::DIES_PER_MODULE,
  parameter int PIXELS = liss_pkg::PIXELS_PER_DIE,
  parameter int DEPTH  = liss_pkg::FIFO_DEPTH
) (
  input  wire logic                           CLK_SYS,
  input  wire logic                           SYS_RST,
  input  wire logic                           LINE_START_PULSE,
  input  wire logic                           PIXEL_SHIFT_CLOCK,
  input  wire logic [liss_pkg::PIX_WIDTH-1:0] PIXEL_SAMPLE,
  output logic      [DIES-1:0]                SCAN_END_PULSE,
  output logic                                PIXEL_VALID,
  input  wire logic                           PIXEL_READY,
  output logic      [liss_pkg::PIX_WIDTH-1:0] PIXEL_DATA,
  output logic      [DIES*PIXELS-1:0]         PIXEL_SELECT,
  output logic                                SAMPLE_STALL
);
  import liss_pkg::*;

  localparam int TOTAL = DIES * PIXELS;

  typedef struct packed {
    logic                       shift_clk_d;
    logic [TOTAL-1:0]           chain;
    logic [DIES-1:0]            scan_end_pulse;
    logic [PIX_WIDTH-1:0]       sample;
    logic                       sample_valid;
  } liss_state_type;

  liss_state_type   state;
  liss_state_type   next_state;
  logic             fall;
  logic             fifo_ready;
  logic [TOTAL-1:0] shifted;

  // falling edge of the shift clock
  assign fall = state.shift_clk_d && !PIXEL_SHIFT_CLOCK;

  // per-die end pulse, fed from the last stage of each die
  function automatic logic [DIES-1:0] die_ends(input logic [TOTAL-1:0] c);
    logic [DIES-1:0] e;
    e = '0;
    for (int d = 0; d < DIES; d++) begin
      e[d] = c[d*PIXELS + PIXELS - 1];
    end
    return e;
  endfunction

  // token shift with start loaded into stage zero
  assign shifted = {state.chain[TOTAL-2:0], LINE_START_PULSE};

  // next state of the whole scan register
  always_comb begin
    next_state             = state;
    next_state.shift_clk_d = PIXEL_SHIFT_CLOCK;
    if (state.sample_valid && fifo_ready) begin
      next_state.sample_valid = 1'b0;
    end
    if (fall) begin
      next_state.chain = shifted;
      next_state.scan_end_pulse   = die_ends(state.chain);
      if (|state.chain) begin
        next_state.sample       = PIXEL_SAMPLE;
        next_state.sample_valid = 1'b1;
      end
    end
  end

  // state register
  always_ff @(posedge CLK_SYS) begin
    if (SYS_RST) begin
      state <= '{shift_clk_d: SHIFT_CLK_RESET, chain: '0, scan_end_pulse: '0,
                 sample: '0, sample_valid: 1'b0};
    end else begin
      state <= next_state;
    end
  end

  assign SCAN_END_PULSE = state.scan_end_pulse;
  assign PIXEL_SELECT   = state.chain;
  assign SAMPLE_STALL   = state.sample_valid && !fifo_ready;

  // pixel buffer toward the readout side
  liss_fifo #(
    .WIDTH (PIX_WIDTH),
    .DEPTH (DEPTH)
  ) u_fifo (
    .clk       (CLK_SYS),
    .rst       (SYS_RST),
    .in_valid  (state.sample_valid),
    .in_ready  (fifo_ready),
    .in_data   (state.sample),
    .out_valid (PIXEL_VALID),
    .out_ready (PIXEL_READY),
    .out_data  (PIXEL_DATA)
  );

  // checks on the token chain and the captured pixel
  token_load_a: assert property (@(posedge CLK_SYS) disable iff (SYS_RST)
    fall && LINE_START_PULSE |=> state.chain[0])
    else $error("start not loaded on falling edge");
  no_load_a: assert property (@(posedge CLK_SYS) disable iff (SYS_RST)
    fall && !LINE_START_PULSE |=> !state.chain[0])
    else $error("token loaded without start");
  multi_token_a: assert property (@(posedge CLK_SYS) disable iff (SYS_RST)
    fall && LINE_START_PULSE && state.chain[0] |=> state.chain[1:0] == 2'b11)
    else $error("second start token lost");
  shift_move_a: assert property (@(posedge CLK_SYS) disable iff (SYS_RST)
    fall |=> state.chain[TOTAL-1:1] == $past(state.chain[TOTAL-2:0]))
    else $error("token did not advance one stage");
  hold_chain_a: assert property (@(posedge CLK_SYS) disable iff (SYS_RST)
    !fall |=> $stable(state.chain))
    else $error("chain moved without falling edge");
  die_end_a: assert property (@(posedge CLK_SYS) disable iff (SYS_RST)
    fall && state.chain[PIXELS-1] |=> SCAN_END_PULSE[0] && state.chain[PIXELS])
    else $error("end pulse or cascade missing");
  pixel_out_a: assert property (@(posedge CLK_SYS) disable iff (SYS_RST)
    fall && (|state.chain) |=> state.sample_valid
      && state.sample == $past(PIXEL_SAMPLE))
    else $error("pixel not captured");
  sample_hold_a: assert property (@(posedge CLK_SYS) disable iff (SYS_RST)
    SAMPLE_STALL && !fall |=> state.sample_valid && $stable(state.sample))
    else $error("stalled pixel not held");

  // checks on the end pulses
  end_clear_a: assert property (@(posedge CLK_SYS) disable iff (SYS_RST)
    fall && !state.chain[PIXELS-1] |=> !SCAN_END_PULSE[0])
    else $error("end pulse without token");
  last_end_a: assert property (@(posedge CLK_SYS) disable iff (SYS_RST)
    fall && state.chain[TOTAL-1] |=> SCAN_END_PULSE[DIES-1])
    else $error("last die end pulse missing");

  // scenario covers
  load_c: cover property (@(posedge CLK_SYS) fall && LINE_START_PULSE);
  end_c: cover property (@(posedge CLK_SYS) SCAN_END_PULSE[DIES-1]);
  full_c: cover property (@(posedge CLK_SYS) !fifo_ready);
  multi_c: cover property (@(posedge CLK_SYS) fall && LINE_START_PULSE && state.chain[0]);
  stall_c: cover property (@(posedge CLK_SYS) SAMPLE_STALL);
endmodule

// pixel fifo with valid and ready on both sides
module liss_fifo #(
  parameter int WIDTH = 16,
  parameter int DEPTH = 32
) (
  input  wire logic             clk,
  input  wire logic             rst,
  input  wire logic             in_valid,
  output logic                  in_ready,
  input  wire logic [WIDTH-1:0] in_data,
  output logic                  out_valid,
  input  wire logic             out_ready,
  output logic      [WIDTH-1:0] out_data
);
  localparam int AW = $clog2(DEPTH);
  typedef struct packed {
    logic [AW-1:0] wr;
    logic [AW-1:0] rd;
    logic [AW:0]   count;
  } liss_fifo_state_type;

  liss_fifo_state_type        state;
  liss_fifo_state_type        next_state;
  logic           [WIDTH-1:0] mem [DEPTH];
  logic                       push;
  logic                       pop;

  // honest full and empty flags
  assign in_ready  = (state.count != (AW+1)'(DEPTH));
  assign out_valid = (state.count != '0);
  assign push      = in_valid && in_ready;
  assign pop       = out_valid && out_ready;
  assign out_data  = mem[state.rd];

  // pointer and count update
  always_comb begin
    next_state = state;
    if (push) begin
      next_state.wr = (state.wr == AW'(DEPTH-1)) ? '0 : state.wr + 1'b1;
    end
    if (pop) begin
      next_state.rd = (state.rd == AW'(DEPTH-1)) ? '0 : state.rd + 1'b1;
    end
    next_state.count = state.count + (AW+1)'(push) - (AW+1)'(pop);
  end

  // state register
  always_ff @(posedge clk) begin
    if (rst) begin
      state <= '0;
    end else begin
      state <= next_state;
    end
  end

  // storage array, no reset needed
  always_ff @(posedge clk) begin
    if (push) begin
      mem[state.wr] <= in_data;
    end
  end

  // checks on the pixel buffer
  fifo_bound_a: assert property (@(posedge clk) disable iff (rst)
    state.count <= (AW+1)'(DEPTH))
    else $error("fifo count past depth");
  head_hold_a: assert property (@(posedge clk) disable iff (rst)
    out_valid && !out_ready |=> out_valid && $stable(out_data))
    else $error("fifo head changed while waiting");
endmodule

// *** pkg/liss_pkg.sv ***
// constants and types for the linear image scan sequencer
package liss_pkg;
  localparam int          PIXELS_PER_DIE   = 128;
  localparam int          DIES_PER_MODULE  = 13;
  localparam int          LINE_PIXELS      = DIES_PER_MODULE * PIXELS_PER_DIE;
  localparam int          FIFO_DEPTH       = 32;
  localparam int          PIX_WIDTH        = 16;
  localparam int          PIX_INDEX_WIDTH  = 11;
  localparam int          CLK_SYS_MHZ      = 250;
  localparam int          MIN_SHIFT_KHZ    = 500;
  localparam int          SHIFT_PERIOD_MAX = (CLK_SYS_MHZ * 1000) / MIN_SHIFT_KHZ;
  localparam logic        TOKEN_RESET      = 1'b0;
  localparam logic        SHIFT_CLK_RESET  = 1'b0;

  typedef enum logic [1:0] {
    LISS_IDLE = 2'b00,
    LISS_SCAN = 2'b01
  } liss_mode_type;
endpackage

// *** core/liss_fifo.sv ***
// pixel fifo module sits beside the sequencer in core/liss_top.sv

// *** verification/liss_ctrl_model.sv ***
// scan controller model driving start pulse and shift clock
`timescale 1ns/1ps
module liss_ctrl_model (
  input  wire logic       clk,
  input  wire logic       run,
  input  wire logic       go,
  input  wire logic [3:0] hi_cyc,
  input  wire logic [3:0] lo_cyc,
  input  wire logic [1:0] starts,
  output logic            sclk,
  output logic            sp
);
  logic [3:0] cnt;
  logic [1:0] left;
  logic       pend;
  // clock stands low while stopped; start rises with the clock and spans the asked falls
  always_ff @(posedge clk) begin
    pend <= go | pend;
    if (!run) begin
      sclk <= 1'b0;
      cnt  <= 4'h0;
      left <= 2'h0;
      sp   <= 1'b0;
      pend <= 1'b0;
    end else if (cnt == (sclk ? hi_cyc : lo_cyc) - 4'h1) begin
      sclk <= ~sclk;
      cnt  <= 4'h0;
      if (!sclk && pend) begin
        left <= starts;
        sp   <= starts != 2'h0;
        pend <= 1'b0;
      end else if (!sclk && left != 2'h0) begin
        left <= left - 2'h1;
        sp   <= left != 2'h1;
      end
    end else begin
      cnt <= cnt + 4'h1;
    end
  end
endmodule

// *** verification/tb_top.sv ***
// testbench for the linear image scan sequencer
`timescale 1ns/1ps
module tb_top;
  import liss_pkg::*;
  logic                       clk = 1'b0, rst = 1'b1, run = 1'b0, go = 1'b0, ready = 1'b1, seq = 1'b1, clr = 1'b0;
  logic [3:0]                 hi = 4'h1, lo = 4'h3;
  logic [1:0]                 starts = 2'h1;
  logic                       sclk, sp, vld, stall, sclk_q;
  logic [PIX_WIDTH-1:0]       smp = 16'h0, dat, last;
  logic [DIES_PER_MODULE-1:0] scan_end_pulse, eos_q;
  logic [LINE_PIXELS-1:0]     sel;
  int                         mismatches = 0, compares = 0, pops = 0, ends = 0;

  liss_ctrl_model liss_ctrl_model_inst (.clk(clk), .run(run), .go(go), .hi_cyc(hi), .lo_cyc(lo),
    .starts(starts), .sclk(sclk), .sp(sp));
  liss_top liss_top_inst (.CLK_SYS(clk), .SYS_RST(rst), .LINE_START_PULSE(sp), .PIXEL_SHIFT_CLOCK(sclk),
    .PIXEL_SAMPLE(smp), .SCAN_END_PULSE(scan_end_pulse), .PIXEL_VALID(vld), .PIXEL_READY(ready), .PIXEL_DATA(dat),
    .PIXEL_SELECT(sel), .SAMPLE_STALL(stall));

  always #2 clk = ~clk;

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    compares++;
    if (seen !== exp) begin
      mismatches++;
      $display("wrong value at %0t: seen %0h expected %0h", $time, seen, exp);
    end
  endtask

  // sample stand-in steps once per shift cycle; pops and end pulses counted
  always @(posedge clk) begin
    sclk_q <= sclk;
    eos_q  <= rst ? '0 : scan_end_pulse;
    if (sclk && !sclk_q) smp <= smp + 16'h1;
    ends <= clr ? 0 : ends + $countones(scan_end_pulse & ~eos_q);
    if (clr) begin
      pops <= 0;
    end else if (vld === 1'b1 && ready) begin
      pops <= pops + 1;
      last <= dat;
      if (seq && pops > 0) chk(dat, last + 16'h1);
    end
  end

  task automatic scan(input logic [3:0] h, input logic [3:0] l, input logic [1:0] n);
    @(posedge clk);
    {hi, lo, starts, run, go} <= {h, l, n, 2'b11};
    clr                       <= 1'b1;
    @(posedge clk);
    go  <= 1'b0;
    clr <= 1'b0;
    repeat (40) @(posedge clk);
  endtask

  // wait until chain, end pulses and fifo are empty, then stop the clock
  task automatic settle;
    int k;
    k = 0;
    while ((sel !== '0 || vld !== 1'b0 || scan_end_pulse !== '0) && k < 20000) begin
      @(posedge clk);
      k++;
    end
    chk(k < 20000, 1);
    run <= 1'b0;
    repeat (4) @(posedge clk);
  endtask

  task automatic t_line;
    scan(4'h1, 4'h3, 2'h1);
    settle;
    chk(pops, LINE_PIXELS);
    chk(ends, DIES_PER_MODULE);
    $display("line test done");
  endtask

  task automatic t_double;
    scan(4'h2, 4'h2, 2'h2);
    @(negedge clk);
    chk($countones(sel), 2);
    settle;
    chk(ends, DIES_PER_MODULE);
    chk(pops, LINE_PIXELS + 1);
    $display("double start test done");
  endtask

  task automatic t_stall;
    seq   <= 1'b0;
    ready <= 1'b0;
    scan(4'h1, 4'h3, 2'h1);
    repeat (160) @(posedge clk);
    @(negedge clk);
    chk(stall, 1);
    chk(vld, 1);
    @(posedge clk);
    ready <= 1'b1;
    settle;
    chk(pops < LINE_PIXELS, 1);
    $display("stall test done");
  endtask

  task automatic wrap_up;
    $display("compares %0d mismatches %0d", compares, mismatches);
    if (mismatches == 0 && compares > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask

  // watchdog, about twice the three scans
  initial begin
    repeat (40000) @(posedge clk);
    mismatches++;
    wrap_up;
  end

  initial begin
    repeat (20) @(posedge clk);
    rst <= 1'b0;
    t_line;
    t_double;
    t_stall;
    wrap_up;
  end
endmodule
